// [core/ppc_port.sv]
// primary bus port: reset handling, address/data and command lines, parity
`timescale 1ns/1ps
module ppc_port
    import ppc_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    // reset and sleep pins
    input wire logic power_on_reset_in,
    input wire logic bus_reset_in,
    input wire logic sleep_hold_in,
    // parity-error response enable from the command register
    input wire logic perr_response_en,
    // address/data pins
    input wire logic [AD_W-1:0] ad_in,
    output logic [AD_W-1:0] ad_out,
    output logic ad_oe,
    // command/byte-enable pins
    input wire logic [CBE_W-1:0] cbe_in,
    output logic [CBE_W-1:0] cbe_out,
    output logic cbe_oe,
    // parity pin
    input wire logic par_in,
    output logic par_out,
    output logic par_oe,
    // parity-error pin, active low, driven only when enabled
    output logic perr_n_out,
    output logic perr_n_oe,
    // words to drive, from the transaction logic
    input wire logic tx_valid,
    output logic tx_ready,
    input wire ppc_word_t tx_word,
    // drive strobes from the transaction logic
    output logic tx_avail,
    input wire logic drive_go,
    input wire logic drive_target,
    // sample qualifiers from the transaction logic
    input wire logic sample_en,
    input wire logic sample_addr,
    // words seen as target
    output logic rx_valid,
    output ppc_word_t rx_word,
    output logic [CBE_W-1:0] rx_cmd,
    output logic [CBE_W-1:0] rx_lanes,
    // status
    output logic parity_error,
    output logic [7:0] parity_error_count,
    output logic bus_floated
);

    ppc_state_t st;
    ppc_state_t next_st;

    logic floated;
    logic clear;
    logic fifo_rst;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic head_valid;
    logic pop;
    logic mismatch;
    logic [WORD_W-1:0] head_bits;
    ppc_word_t head;

    // either reset pin floats the bus; only sleep-hold can spare the state
    assign floated = st.por_s2 | st.bus_s2;
    // power-on reset always clears, bus reset clears unless sleep-hold is on
    assign clear = st.por_s2 | (st.bus_s2 & ~st.slp_s2);
    assign fifo_rst = rst | clear;

    // refuse new words while floated so nothing piles up during reset
    assign fifo_in_valid = tx_valid & ~floated;
    assign tx_ready = fifo_in_ready & ~floated;

    ppc_fifo #(
        .W(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .clock(clock),
        .rst(fifo_rst),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(tx_word),
        .out_valid(head_valid),
        .out_ready(pop),
        .out_data(head_bits)
    );

    assign head = ppc_word_t'(head_bits);
    assign tx_avail = head_valid & ~floated;

    // a word leaves only when the transaction logic asks and the bus is live
    assign pop = drive_go & head_valid & ~floated;

    // the check result pairs the held parity with the parity line one clock on
    assign mismatch = st.chk_pend & (st.pin_s2.par != st.chk_par);

    always_comb
    begin
        next_st = st;

        // two flip-flops on every pin, all taken on the rising edge
        next_st.por_s1 = power_on_reset_in;
        next_st.por_s2 = st.por_s1;
        next_st.bus_s1 = bus_reset_in;
        next_st.bus_s2 = st.bus_s1;
        next_st.slp_s1 = sleep_hold_in;
        next_st.slp_s2 = st.slp_s1;
        next_st.pin_s1 = {ad_in, cbe_in, par_in};
        next_st.pin_s2 = st.pin_s1;

        // qualifiers are delayed to line up with the pin samples
        next_st.smp_q1 = sample_en & ~floated;
        next_st.smp_q2 = st.smp_q1;
        next_st.adr_q1 = sample_addr;
        next_st.adr_q2 = st.adr_q1;

        // single-cycle status strobes
        next_st.rx_valid = 1'b0;
        next_st.par_err = 1'b0;
        next_st.chk_pend = 1'b0;

        // target capture: address phase gives command, data phase gives lanes
        if (st.smp_q2)
        begin
            next_st.rx.addr_phase = st.adr_q2;
            next_st.rx.ad = st.pin_s2.ad;
            next_st.rx.cbe = st.pin_s2.cbe;
            next_st.rx_valid = 1'b1;
            if (st.adr_q2)
            begin
                next_st.rx_cmd = st.pin_s2.cbe;
            end
            else
            begin
                next_st.rx_lanes = ppc_lane_mask(st.pin_s2.cbe);
            end
            // hold the computed parity until the initiator's parity arrives
            next_st.chk_pend = 1'b1;
            next_st.chk_par = ppc_even_par(st.pin_s2.ad, st.pin_s2.cbe);
        end

        // mismatch is counted up to 255 whatever the enable, the pin only follows the enable
        if (mismatch)
        begin
            next_st.par_err = 1'b1;
            if (st.err_count != 8'hff)
            begin
                next_st.err_count = 8'(st.err_count + 1'b1);
            end
        end

        // parity-error pin: low for one clock, then high one clock before release
        case (st.perr_st)
            PE_IDLE:
            begin
                if (mismatch && perr_response_en)
                begin
                    next_st.perr_st = PE_LOW;
                end
            end
            PE_LOW:
            begin
                if (mismatch && perr_response_en)
                begin
                    next_st.perr_st = PE_LOW;
                end
                else
                begin
                    next_st.perr_st = PE_HIGH;
                end
            end
            PE_HIGH:
            begin
                if (mismatch && perr_response_en)
                begin
                    next_st.perr_st = PE_LOW;
                end
                else
                begin
                    next_st.perr_st = PE_IDLE;
                end
            end
            default:
            begin
                next_st.perr_st = PE_IDLE;
            end
        endcase

        // drive path: lines stand one clock, parity follows one clock later
        next_st.ad_oe = 1'b0;
        next_st.cbe_oe = 1'b0;
        next_st.par_pend = 1'b0;
        next_st.par_oe = st.par_pend;
        next_st.par_out = st.drv.par;
        if (pop)
        begin
            next_st.drv.ad = head.ad;
            next_st.drv.cbe = head.cbe;
            // as read target the initiator owns the command lines
            next_st.drv.par = ppc_even_par(head.ad, head.cbe);
            next_st.ad_oe = 1'b1;
            next_st.cbe_oe = ~drive_target;
            next_st.par_pend = 1'b1;
        end

        // clearing keeps the reset and sleep-hold pin synchronisers running so release is seen
        if (clear)
        begin
            next_st = ST_RST;
            next_st.por_s1 = power_on_reset_in;
            next_st.por_s2 = st.por_s1;
            next_st.bus_s1 = bus_reset_in;
            next_st.bus_s2 = st.bus_s1;
            next_st.slp_s1 = sleep_hold_in;
            next_st.slp_s2 = st.slp_s1;
        end
    end

    // one register for all state; reset leaves the bus floated
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            st <= ST_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

    // enables are gated by the reset pins, so a held state never leaks out
    assign ad_out = st.drv.ad;
    assign ad_oe = st.ad_oe & ~floated;
    assign cbe_out = st.drv.cbe;
    assign cbe_oe = st.cbe_oe & ~floated;
    assign par_out = st.par_out;
    assign par_oe = st.par_oe & ~floated;
    assign perr_n_out = (st.perr_st == PE_LOW) ? ~PERR_IDLE_LEVEL : PERR_IDLE_LEVEL;
    assign perr_n_oe = (st.perr_st != PE_IDLE) & ~floated;

    // target-side results and status
    assign rx_valid = st.rx_valid;
    assign rx_word = st.rx;
    assign rx_cmd = st.rx_cmd;
    assign rx_lanes = st.rx_lanes;
    assign parity_error = st.par_err;
    assign parity_error_count = st.err_count;
    assign bus_floated = floated;

endmodule

// [core/ppc_pkg.sv]
// constants, carrier types and state layout for the primary bus port core
package ppc_pkg;

    localparam int AD_W = 32;
    localparam int CBE_W = 4;
    localparam int FIFO_DEPTH = 8;
    localparam int CLK_PERIOD_NS = 50;

    // reset values
    localparam logic POR_SYNC_RST = 1'b1;
    localparam logic BUS_SYNC_RST = 1'b1;
    localparam logic PERR_IDLE_LEVEL = 1'b1;

    // one word to drive, or one word seen on the bus
    typedef struct packed {
        logic addr_phase;
        logic [CBE_W-1:0] cbe;
        logic [AD_W-1:0] ad;
    } ppc_word_t;

    localparam int WORD_W = $bits(ppc_word_t);

    // the parity-covered bus lines as seen at the pins
    typedef struct packed {
        logic [AD_W-1:0] ad;
        logic [CBE_W-1:0] cbe;
        logic par;
    } ppc_bus_t;

    typedef enum logic [2:0] {
        PE_IDLE = 3'h1,
        PE_LOW = 3'h2,
        PE_HIGH = 3'h4
    } ppc_perr_t;

    typedef struct packed {
        logic por_s1;
        logic por_s2;
        logic bus_s1;
        logic bus_s2;
        logic slp_s1;
        logic slp_s2;
        ppc_bus_t pin_s1;
        ppc_bus_t pin_s2;
        logic smp_q1;
        logic smp_q2;
        logic adr_q1;
        logic adr_q2;
        logic chk_pend;
        logic chk_par;
        ppc_bus_t drv;
        logic ad_oe;
        logic cbe_oe;
        logic par_pend;
        logic par_oe;
        logic par_out;
        ppc_perr_t perr_st;
        ppc_word_t rx;
        logic [CBE_W-1:0] rx_cmd;
        logic [CBE_W-1:0] rx_lanes;
        logic rx_valid;
        logic par_err;
        logic [7:0] err_count;
    } ppc_state_t;

    localparam ppc_state_t ST_RST = '{
        por_s1: POR_SYNC_RST,
        por_s2: POR_SYNC_RST,
        bus_s1: BUS_SYNC_RST,
        bus_s2: BUS_SYNC_RST,
        perr_st: PE_IDLE,
        default: '0
    };

    // even parity: the parity line makes the count of ones even
    function automatic logic ppc_even_par(input logic [AD_W-1:0] ad, input logic [CBE_W-1:0] cbe);
        return ^{ad, cbe};
    endfunction

    // active-low byte enables to a lane mask, bit n marks byte lane n valid
    function automatic logic [CBE_W-1:0] ppc_lane_mask(input logic [CBE_W-1:0] cbe);
        return ~cbe;
    endfunction

endpackage

// [core/ppc_fifo.sv]
// small first-in first-out buffer in flip-flops, valid/ready on both sides
`timescale 1ns/1ps
module ppc_fifo
    import ppc_pkg::*;
#(
    parameter int W = WORD_W,
    parameter int DEPTH = FIFO_DEPTH
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } ppc_fifo_state_t;

    ppc_fifo_state_t st;
    ppc_fifo_state_t next_st;
    logic push;
    logic pop;

    // honest flags straight from the count
    assign in_ready = (st.cnt != FULL_COUNT);
    assign out_valid = (st.cnt != '0);
    assign out_data = st.mem[st.rd];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // pointers wrap by width, so depth is kept a power of two
    always_comb
    begin
        next_st = st;
        if (push)
        begin
            next_st.mem[st.wr] = in_data;
            next_st.wr = AW'(st.wr + 1'b1);
        end
        if (pop)
        begin
            next_st.rd = AW'(st.rd + 1'b1);
        end
        if (push && !pop)
        begin
            next_st.cnt = (AW+1)'(st.cnt + 1'b1);
        end
        else if (pop && !push)
        begin
            next_st.cnt = (AW+1)'(st.cnt - 1'b1);
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

endmodule

// [verification/ppc_port_props.sv]
// concurrent checks on the primary bus port pins
`timescale 1ns/1ps
module ppc_port_props
    import ppc_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic perr_response_en,
    input wire logic [AD_W-1:0] ad_in,
    input wire logic [AD_W-1:0] ad_out,
    input wire logic ad_oe,
    input wire logic [CBE_W-1:0] cbe_in,
    input wire logic [CBE_W-1:0] cbe_out,
    input wire logic cbe_oe,
    input wire logic par_in,
    input wire logic par_out,
    input wire logic par_oe,
    input wire logic perr_n_out,
    input wire logic perr_n_oe,
    input wire logic tx_ready,
    input wire logic tx_avail,
    input wire logic drive_go,
    input wire logic drive_target,
    input wire logic sample_en,
    input wire logic rx_valid,
    input wire ppc_word_t rx_word,
    input wire logic [CBE_W-1:0] rx_lanes,
    input wire logic parity_error,
    input wire logic bus_floated
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // a reset pin forces every pin driver off at once
    chk_float_quiet: assert property (
        bus_floated |-> !(ad_oe | cbe_oe | par_oe | perr_n_oe)) else $error("driver on while floated");
    chk_float_idle: assert property (
        bus_floated |-> !tx_ready && !tx_avail) else $error("port active while floated");
    // drive path: lines one cycle after go, parity one cycle behind the lines
    chk_drive_start: assert property (
        drive_go && tx_avail && !drive_target |=> (ad_oe && cbe_oe) || bus_floated)
        else $error("lines not driven after go");
    chk_read_cbe: assert property (
        drive_go && tx_avail && drive_target |=> !cbe_oe) else $error("cbe driven on read");
    chk_par_follow: assert property (
        ad_oe |=> par_oe || bus_floated) else $error("parity not one clock behind");
    chk_par_value: assert property (
        par_oe && $past(cbe_oe) |-> par_out == (^{$past(ad_out), $past(cbe_out)}))
        else $error("driven parity wrong");
    // target side: two pin flops plus the capture register put rx_valid three cycles on
    chk_rx_time: assert property (
        sample_en && !bus_floated |-> ##3 rx_valid) else $error("capture late");
    chk_rx_data: assert property (
        rx_valid |-> rx_word.ad == $past(ad_in, 3) && rx_word.cbe == $past(cbe_in, 3))
        else $error("captured word wrong");
    chk_rx_lanes: assert property (
        rx_valid && !rx_word.addr_phase |-> rx_lanes == ~rx_word.cbe) else $error("lanes wrong");
    chk_par_check: assert property (
        rx_valid |=> parity_error == (^{$past(ad_in, 4), $past(cbe_in, 4), $past(par_in, 3)}))
        else $error("parity compare wrong");
    chk_perr_drive: assert property (
        parity_error && perr_response_en |-> perr_n_oe && !perr_n_out) else $error("no perr");
    chk_perr_gate: assert property (
        $rose(perr_n_oe) |-> parity_error && perr_response_en) else $error("perr not enabled");
    cover property (parity_error && perr_n_oe);
    cover property (par_oe && !cbe_oe);
    cover property (bus_floated ##1 !bus_floated);
endmodule
bind ppc_port ppc_port_props u_props (.*);

// [verification/ppc_agent.sv]
// far-side bus agent: drives address/data, command and parity as initiator
`timescale 1ns/1ps
module ppc_agent
    import ppc_pkg::*;
(
    input wire logic clock,
    input wire logic go,
    input wire logic bad,
    input wire logic [AD_W-1:0] a,
    input wire logic [CBE_W-1:0] c,
    output logic [AD_W-1:0] ad = '0,
    output logic [CBE_W-1:0] cbe = '0,
    output logic par = 1'b0
);
    logic ph = 1'b0;
    // released lines show the inverse, so a stale value never passes for fresh
    always @(posedge clock)
    begin
        ph <= go;
        ad <= go ? a : ~ad;
        cbe <= go ? c : ~cbe;
        par <= ph ? ^{ad, cbe, bad} : ~par;
    end
endmodule

// [verification/testbench.sv]
// self-checking bench for the primary bus port
`timescale 1ns/1ps
module testbench
    import ppc_pkg::*;
;
    logic clock = 0, rst = 1, power_on_reset_in = 0, bus_reset_in = 0;
    logic sleep_hold_in = 0, perr_response_en = 0, go = 0, bad = 0;
    logic [AD_W-1:0] ad_in, ad_out, pa = '0;
    logic [CBE_W-1:0] cbe_in, cbe_out, rx_cmd, rx_lanes, pc = '0;
    logic ad_oe, cbe_oe, par_in, par_out, par_oe, perr_n_out, perr_n_oe;
    logic tx_valid = 0, drive_go = 0, drive_target = 0, sample_en = 0, sample_addr = 0;
    logic tx_ready, tx_avail, rx_valid, parity_error, bus_floated;
    logic [7:0] parity_error_count;
    ppc_word_t tx_word = '0, rx_word, w;
    int fails = 0, checked = 0, cyc = 0, nerr = 0;

    ppc_port u_dut (.*);
    ppc_agent u_agent (.clock(clock), .go(go), .bad(bad), .a(pa), .c(pc), .ad(ad_in),
        .cbe(cbe_in), .par(par_in));

    // clock and hang guard
    always #25 clock = ~clock;
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 2000)
        begin
            fails++;
            end_of_test;
        end
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic ppc_word_t wd(input int i);
        return {1'b0, 4'(i), 32'(32'h0101_0101 * i)};
    endfunction

    // one initiator phase from the agent, taken as target
    task automatic send(input logic ap, input logic [3:0] c, input logic [31:0] a, input logic b);
        @(posedge clock);
        go <= 1'b1;
        pa <= a;
        pc <= c;
        bad <= b;
        @(posedge clock);
        go <= 1'b0;
        sample_en <= 1'b1;
        sample_addr <= ap;
        @(posedge clock);
        sample_en <= 1'b0;
        // pins pass two flops and the capture register before rx_valid stands
        repeat (3) @(negedge clock);
        check({rx_valid, rx_word}, {1'b1, ap, c, a});
        @(negedge clock);
        check(parity_error, b);
        check({perr_n_oe, perr_n_out}, {b & perr_response_en, !(b & perr_response_en)});
        nerr += b;
        repeat (3) @(negedge clock);
    endtask

    task automatic t_target;
        @(posedge clock);
        perr_response_en <= 1'b1;
        send(1'b1, 4'h7, 32'h1000_0040, 1'b0);
        check(rx_cmd, 4'h7);
        for (int i = 0; i < 4; i++)
        begin
            send(1'b0, ~(4'h1 << i), 32'h3c5a_96e1 ^ i, i[0]);
            check(rx_lanes, 4'h1 << i);
        end
        @(posedge clock);
        perr_response_en <= 1'b0;
        send(1'b0, 4'h0, 32'hffff_0000, 1'b1);
        $display("target test done");
    endtask

    // fill the buffer until it refuses, then burst it out as initiator
    task automatic t_drive;
        @(posedge clock);
        tx_valid <= 1'b1;
        for (int i = 0; i < FIFO_DEPTH; i++)
        begin
            tx_word <= wd(i);
            @(posedge clock);
        end
        tx_valid <= 1'b0;
        drive_go <= 1'b1;
        @(negedge clock);
        check(tx_ready, 1'b0);
        for (int i = 0; i < FIFO_DEPTH; i++)
        begin
            @(posedge clock);
            if (i == FIFO_DEPTH - 1)
                drive_go <= 1'b0;
            @(negedge clock);
            w = wd(i);
            check({ad_oe, cbe_oe, cbe_out, ad_out}, {2'b11, w.cbe, w.ad});
            w = wd(i - 1);
            if (i > 0)
                check({par_oe, par_out}, {1'b1, ^{w.ad, w.cbe}});
        end
        @(negedge clock);
        // the trailing parity covers the last word of the burst
        w = wd(FIFO_DEPTH - 1);
        check({ad_oe, tx_avail, par_oe, par_out}, {3'b001, ^{w.ad, w.cbe}});
        $display("drive test done");
    endtask

    // target read: data and parity driven, command lines left alone
    task automatic t_read;
        w = wd(9);
        @(posedge clock);
        tx_valid <= 1'b1;
        tx_word <= w;
        @(posedge clock);
        tx_valid <= 1'b0;
        drive_go <= 1'b1;
        drive_target <= 1'b1;
        @(posedge clock);
        drive_go <= 1'b0;
        @(negedge clock);
        check({ad_oe, cbe_oe, ad_out}, {2'b10, w.ad});
        @(negedge clock);
        check({par_oe, par_out}, {1'b1, ^{w.ad, w.cbe}});
        $display("read test done");
    endtask

    task automatic t_resets;
        @(posedge clock);
        sleep_hold_in <= 1'b1;
        bus_reset_in <= 1'b1;
        repeat (4) @(negedge clock);
        check({bus_floated, ad_oe, par_oe, tx_ready}, 4'h8);
        @(posedge clock);
        bus_reset_in <= 1'b0;
        repeat (4) @(negedge clock);
        check({bus_floated, parity_error_count}, nerr);
        @(posedge clock);
        sleep_hold_in <= 1'b0;
        bus_reset_in <= 1'b1;
        tx_valid <= 1'b1;
        repeat (4) @(negedge clock);
        check({bus_floated, tx_ready}, 2'b10);
        @(posedge clock);
        bus_reset_in <= 1'b0;
        tx_valid <= 1'b0;
        repeat (4) @(negedge clock);
        check({bus_floated, parity_error_count}, 9'h0);
        @(posedge clock);
        tx_valid <= 1'b1;
        @(posedge clock);
        tx_valid <= 1'b0;
        power_on_reset_in <= 1'b1;
        repeat (4) @(negedge clock);
        check({bus_floated, perr_n_oe, cbe_oe}, 3'b100);
        @(posedge clock);
        power_on_reset_in <= 1'b0;
        repeat (4) @(negedge clock);
        check({bus_floated, tx_avail}, 2'b00);
        $display("reset test done");
    endtask

    task automatic end_of_test;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // main sequence
    initial
    begin
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        repeat (3) @(negedge clock);
        check({bus_floated, ad_oe, perr_n_out}, 3'b001);
        t_target;
        t_drive;
        t_read;
        t_resets;
        end_of_test;
    end
endmodule
